// ---- eeprom_i2c_monitor.sv ----
module eeprom_i2c_monitor
   import eeprom_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   int busy_len;
   logic [3:0] stop_age;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || !busy_out) begin
         busy_len <= 0;
      end else begin
         busy_len <= busy_len + 1;
      end
   end
   // The age saturates so that an old STOP never looks recent again.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || (scl_in && $past(scl_in) && $rose(sda_in))) begin
         stop_age <= 4'h0;
      end else if (stop_age != 4'hf) begin
         stop_age <= stop_age + 4'h1;
      end
   end
   sequence start_s;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence stop_s;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   sda_value_a: assert property (sda_out == 1'b0)
      else $error("sda value not low");
   oe_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
      else $error("sda drive changed while clock high");
   oe_hold_a: assert property (sda_oe_out && $rose(scl_in) |=> sda_oe_out)
      else $error("acknowledge dropped during clock pulse");
   busy_quiet_a: assert property (busy_out |-> !sda_oe_out)
      else $error("device drove sda while programming");
   busy_len_a: assert property (busy_len <= PROG_CYCLES + DRAIN_DIV * PAGE_BYTES + 8)
      else $error("programming lasted too long");
   busy_cause_a: assert property ($rose(busy_out) |-> stop_age <= 4'h6)
      else $error("programming began without a stop");
   stop_idle_a: assert property (stop_s |=> !sda_oe_out [*2])
      else $error("device drove sda after stop");
   start_idle_a: assert property (start_s |-> !sda_oe_out ##1 !sda_oe_out)
      else $error("device drove sda at start");
endmodule

bind eeprom_i2c_slave eeprom_i2c_monitor #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_mon (
   .clk_sys_in, .sys_rst_in, .scl_in, .sda_in, .wp_in, .sda_out, .sda_oe_out, .busy_out);

// ---- eeprom_i2c_slave.sv ----
// Operation
// - The receiver holds the data line low through the ninth clock pulse.
// - Acknowledge matching slave address, and every byte while selected for writing, except data bytes while write protect is high.
// - Read mode shifts out eight bits, releases line, samples master acknowledge.
// - Without master acknowledge, stop sending and idle until STOP.
// - Byte write is address, word address into pointer, one data byte, STOP.
// - STOP after a write starts programming; all requests ignored meanwhile.
// - A page write may carry up to sixteen data bytes.
// - Each written byte increments only the low page bits of the pointer.
// - Over sixteen bytes the page index wraps and overwrites buffered bytes.
// - STOP commits all buffered page bytes in one programming cycle.
// - While programming, a write-direction address gets no acknowledge.
// - With write protect high, first data byte is refused and nothing programs.
// - Reads use direction bit one: current, random and sequential forms.
// - The counter holds last accessed location plus one.
// - Past the top array location the read counter wraps to zero.
// - Current read: acknowledge address, send one byte, master nacks and stops.
// - Random read is a dummy write of the word address, then a read.
// - Reads increment every address bit, traversing the whole array.
// - START is data falling with clock high, STOP data rising with clock high.
// - The upper four slave address bits must be 1010.
// - The next three slave address bits give the high array address bits.
module eeprom_i2c_slave
   import eeprom_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic busy_out
);
   // ==========================================================
   // Declarations
   // ==========================================================
   // Limitation: ADDR_W must lie between 9 and 11 so that at least one
   // slave address bit feeds the array address.
   localparam int HI_W = ADDR_W - 8;
   localparam int PG_W = ADDR_W - PAGE_W;
   localparam int TW = $clog2(PROG_CYCLES + 1);
   localparam int FW = $bits(prog_word_t);

   bus_state_t state;
   logic scl_q;
   logic sda_q;
   logic [3:0] cnt;
   logic [7:0] rx;
   logic [7:0] tx;
   logic [ADDR_W-1:0] ptr;
   logic [HI_W-1:0] hi;
   logic rw;
   logic acked;
   logic [7:0] mem [2**ADDR_W];
   logic [7:0] pbuf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pvalid;
   logic cmt_active;
   logic [PAGE_W-1:0] cidx;
   logic [PG_W-1:0] cpage;
   logic [TW-1:0] prog_cnt;
   logic [1:0] div_cnt;
   logic drain_en;
   logic f_in_valid;
   logic f_in_ready;
   logic f_out_valid;
   logic [FW-1:0] f_out_data;
   prog_word_t f_in_word;
   prog_word_t f_out_word;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic byte_done;
   logic busy;
   logic dev_ok;
   logic pb_we;
   logic cmt_start;

   function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
      page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
   endfunction

   // ==========================================================
   // Bus condition detection
   // ==========================================================
   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_det = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_det = scl_in & scl_q & ~sda_q & sda_in;
   assign byte_done = scl_fall & (cnt == 4'(BIT_ACK));
   assign busy = cmt_active | f_out_valid | (prog_cnt != '0);
   // Any request during programming is left without acknowledge.
   assign dev_ok = (rx[7:4] == DEV_CODE) & ~busy;
   assign pb_we = byte_done & (state == ST_DATA) & ~wp_in;
   assign cmt_start = stop_det & (|pvalid) & ~cmt_active;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // ==========================================================
   // Protocol engine
   // ==========================================================
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         cnt <= '0;
         rx <= '0;
         tx <= '0;
         ptr <= '0;
         hi <= '0;
         rw <= 1'b0;
         acked <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (start_det) begin
         state <= ST_DEV;
         cnt <= '0;
         sda_oe_out <= 1'b0;
      end else if (stop_det) begin
         state <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE, ST_WAIT: begin
               sda_oe_out <= 1'b0;
            end
            ST_DEV, ST_WORD, ST_DATA: begin
               if (scl_rise) begin
                  cnt <= cnt + 1'b1;
                  if (cnt < 4'(BIT_ACK)) begin
                     rx <= {rx[6:0], sda_in};
                  end
               end
               if (byte_done) begin
                  unique case (state)
                     ST_DEV: begin
                        acked <= dev_ok;
                        sda_oe_out <= dev_ok;
                        rw <= rx[0];
                        hi <= rx[HI_W:1];
                     end
                     ST_WORD: begin
                        acked <= 1'b1;
                        sda_oe_out <= 1'b1;
                        ptr <= {hi, rx};
                     end
                     ST_DATA: begin
                        acked <= ~wp_in;
                        sda_oe_out <= ~wp_in;
                        if (~wp_in) begin
                           ptr <= page_inc(ptr);
                        end
                     end
                  endcase
               end
               if (scl_fall && cnt == 4'(BIT_DONE)) begin
                  cnt <= '0;
                  sda_oe_out <= 1'b0;
                  if (!acked) begin
                     state <= ST_WAIT;
                  end else if (state == ST_DEV && rw) begin
                     state <= ST_SEND;
                     tx <= mem[ptr];
                     sda_oe_out <= ~mem[ptr][7];
                     ptr <= ptr + 1'b1;
                  end else if (state == ST_DEV) begin
                     state <= ST_WORD;
                  end else begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_SEND: begin
               if (scl_rise) begin
                  cnt <= cnt + 1'b1;
                  if (cnt == 4'(BIT_ACK)) begin
                     acked <= ~sda_in;
                  end
               end
               if (scl_fall) begin
                  if (cnt < 4'(BIT_ACK)) begin
                     tx <= {tx[6:0], 1'b0};
                     sda_oe_out <= ~tx[6];
                  end else if (cnt == 4'(BIT_ACK)) begin
                     sda_oe_out <= 1'b0;
                  end else if (acked) begin
                     cnt <= '0;
                     tx <= mem[ptr];
                     sda_oe_out <= ~mem[ptr][7];
                     ptr <= ptr + 1'b1;
                  end else begin
                     state <= ST_WAIT;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Page buffer and commit
   // ==========================================================
   assign f_in_valid = cmt_active & pvalid[cidx];
   assign f_in_word = '{addr: MAX_ADDR_W'({cpage, cidx}), data: pbuf[cidx]};

   always_ff @(posedge clk_sys_in) begin
      if (pb_we) begin
         pbuf[ptr[PAGE_W-1:0]] <= rx;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         pvalid <= '0;
         cmt_active <= 1'b0;
         cidx <= '0;
         cpage <= '0;
      end else if (cmt_start) begin
         cmt_active <= 1'b1;
         cidx <= '0;
         cpage <= ptr[ADDR_W-1:PAGE_W];
      end else if (cmt_active) begin
         if (!pvalid[cidx] || f_in_ready) begin
            pvalid[cidx] <= 1'b0;
            cidx <= cidx + 1'b1;
            if (cidx == PAGE_W'(PAGE_BYTES - 1)) begin
               cmt_active <= 1'b0;
            end
         end
      end else if (start_det) begin
         // A write broken off by a new START does not program.
         pvalid <= '0;
      end else if (pb_we) begin
         pvalid[ptr[PAGE_W-1:0]] <= 1'b1;
      end
   end

   // ==========================================================
   // Programming timer and array write
   // ==========================================================
   // The array takes one byte per drain pulse, so the buffer in front of it
   // fills and stalls the commit walk; busy holds until the timer, the walk and the drain are all done.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         prog_cnt <= '0;
      end else if (cmt_start) begin
         prog_cnt <= TW'(PROG_CYCLES);
      end else if (prog_cnt != '0) begin
         prog_cnt <= prog_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         div_cnt <= '0;
         drain_en <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         drain_en <= (div_cnt == 2'(DRAIN_DIV - 1));
      end
   end

   fifo_buf #(
      .W(FW),
      .D(FIFO_DEPTH)
   ) prog_fifo (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(f_in_valid),
      .in_ready_out(f_in_ready),
      .in_data_in(f_in_word),
      .out_valid_out(f_out_valid),
      .out_ready_in(drain_en),
      .out_data_out(f_out_data)
   );

   assign f_out_word = prog_word_t'(f_out_data);

   always_ff @(posedge clk_sys_in) begin
      if (f_out_valid && drain_en) begin
         mem[f_out_word.addr[ADDR_W-1:0]] <= f_out_word.data;
      end
   end

   // ==========================================================
   // Output registers
   // ==========================================================
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         sda_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         busy_out <= busy;
      end
   end
endmodule

// ---- eeprom_pkg.sv ----
package eeprom_pkg;

   // ==========================================================
   // Array geometry and addressing
   // ==========================================================
   localparam int ADDR_W_DEF = 11;
   localparam int MAX_ADDR_W = 11;
   localparam int PAGE_W = 4;
   localparam int PAGE_BYTES = 16;
   localparam logic [3:0] DEV_CODE = 4'ha;
   localparam int BIT_ACK = 8;
   localparam int BIT_DONE = 9;

   // ==========================================================
   // Timing and buffering
   // ==========================================================
   localparam int PROG_CYCLES_DEF = 10000;
   localparam int DRAIN_DIV = 4;
   localparam int FIFO_DEPTH = 8;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DEV = 6'h02,
      ST_WORD = 6'h04,
      ST_DATA = 6'h08,
      ST_SEND = 6'h10,
      ST_WAIT = 6'h20
   } bus_state_t;

   typedef struct packed {
      logic [MAX_ADDR_W-1:0] addr;
      logic [7:0] data;
   } prog_word_t;

endpackage

// ---- fifo_buf.sv ----
module fifo_buf #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   logic [W-1:0] store [D];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic push;
   logic pop;

   assign in_ready_out = (count != CW'(D));
   assign out_valid_out = (count != '0);
   assign out_data_out = store[rd_ptr];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         store[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + CW'(push) - CW'(pop);
      end
   end
endmodule

// ---- i2c_master.sv ----
module i2c_master (
   input wire logic clk_sys_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // Four clocks a phase, twice what the slave needs, keeps sda away from clock edges.
   task automatic hp();
      repeat (4) @(negedge clk_sys_in);
   endtask
   task automatic bit_io(input logic b, output logic s);
      sda_oe_out = ~b;
      hp();
      scl_out = 1'b1;
      hp();
      s = sda_in;
      scl_out = 1'b0;
      hp();
   endtask
   task automatic start();
      sda_oe_out = 1'b0;
      hp();
      scl_out = 1'b1;
      hp();
      sda_oe_out = 1'b1;
      hp();
      scl_out = 1'b0;
      hp();
   endtask
   task automatic stop();
      sda_oe_out = 1'b1;
      hp();
      scl_out = 1'b1;
      hp();
      sda_oe_out = 1'b0;
      hp();
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~ack, s);
   endtask
endmodule

// ---- testbench.sv ----
module testbench import eeprom_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Long enough that the first poll is refused, short enough for a quick run.
   localparam int PROG = 300;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic wp_in = 1'b0;
   logic scl, m_oe, sda, sda_out, sda_oe_out, busy_out, k;
   logic [7:0] d;
   int n_errors = 0;
   int checks = 0;
   always #2 clk_sys_in = ~clk_sys_in;
   assign sda = !(m_oe || sda_oe_out);
   i2c_master u_i2c_master (.clk_sys_in, .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
   eeprom_i2c_slave #(.PROG_CYCLES(PROG)) u_eeprom_i2c_slave (.clk_sys_in, .sys_rst_in, .scl_in(scl),
      .sda_in(sda), .wp_in, .sda_out, .sda_oe_out, .busy_out);
   task automatic close_out();
      $display("Checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic addr(input logic [10:0] a);
      u_i2c_master.start();
      u_i2c_master.wbyte({DEV_CODE, a[10:8], 1'b0}, k);
      check("dev ack", 8'h01, {7'h00, k});
      u_i2c_master.wbyte(a[7:0], k);
      check("word ack", 8'h01, {7'h00, k});
   endtask
   task automatic wr(input logic [10:0] a, input int n, input logic [7:0] b);
      int nak;
      addr(a);
      for (int i = 0; i < n; i++) begin
         u_i2c_master.wbyte(b + 8'(i), k);
         check("data ack", 8'h01, {7'h00, k});
      end
      u_i2c_master.stop();
      check("busy", 8'h01, {7'h00, busy_out});
      for (nak = 0; nak < 40; nak++) begin
         u_i2c_master.start();
         u_i2c_master.wbyte({DEV_CODE, 4'h0}, k);
         if (k === 1'b1) break;
      end
      u_i2c_master.stop();
      if (nak == 40) begin
         n_errors++;
         close_out();
      end
      check("polls refused", 8'h01, 8'(nak > 0));
   endtask
   task automatic rd(input logic [10:0] a, input bit cur, input logic [7:0] e[$]);
      if (!cur) begin
         addr(a);
      end
      u_i2c_master.start();
      u_i2c_master.wbyte({DEV_CODE, a[10:8], 1'b1}, k);
      check("read ack", 8'h01, {7'h00, k});
      foreach (e[i]) begin
         u_i2c_master.rbyte(i < e.size() - 1, d);
         check("read data", e[i], d);
      end
      u_i2c_master.stop();
   endtask
   task automatic t_write();
      wr(11'h000, 1, 8'h5a);
      wr(11'h001, 1, 8'ha5);
      wr(11'h7f8, 10, 8'h80);
      $display("Test write finished");
   endtask
   task automatic t_protect();
      wp_in = 1'b1;
      addr(11'h7f8);
      u_i2c_master.wbyte(8'h11, k);
      check("protect nack", 8'h00, {7'h00, k});
      u_i2c_master.stop();
      check("protect idle", 8'h00, {7'h00, busy_out});
      wp_in = 1'b0;
      $display("Test protect finished");
   endtask
   task automatic t_read();
      rd(11'h7f8, 0, '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h5a});
      rd(11'h001, 1, '{8'ha5});
      rd(11'h7f0, 0, '{8'h88, 8'h89});
      $display("Test read finished");
   endtask
   task automatic t_foreign();
      u_i2c_master.start();
      u_i2c_master.wbyte(8'hb0, k);
      check("foreign nack", 8'h00, {7'h00, k});
      u_i2c_master.stop();
      check("sda value", 8'h00, {7'h00, sda_out});
      $display("Test foreign finished");
   endtask
   initial begin
      repeat (12) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      t_write();
      t_protect();
      t_read();
      t_foreign();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      n_errors++;
      close_out();
   end
endmodule
